// ---- hppc_params.svh ----
`ifndef HPPC_PARAMS_SVH
`define HPPC_PARAMS_SVH

`define HPPC_NPORT          4
`define HPPC_NGPIO          4
`define HPPC_CLK_MHZ        200
`define HPPC_EN_HOLD_NS     12500
`define HPPC_EN_HOLD_CYC    ((`HPPC_EN_HOLD_NS * `HPPC_CLK_MHZ + 999) / 1000)
`define HPPC_T_POR_US       100
`define HPPC_T_POR_CYC      (`HPPC_T_POR_US * `HPPC_CLK_MHZ)
`define HPPC_RST_STAT       12'hFFF
`define HPPC_RST_GPIO       4'h0
`define HPPC_RST_BYTE       8'h00

`endif

// ---- hppc_pkg.sv ----
package hppc_pkg;

  typedef enum logic [1:0] {
    HPPC_OFF    = 2'b00,
    HPPC_SETTLE = 2'b01,
    HPPC_READY  = 2'b10
  } hppc_pwr_t;

  // index = port + {a=0, b=4, c=8}
  typedef struct packed {
    logic [3:0] in_c;
    logic [3:0] in_b;
    logic [3:0] in_a;
  } hppc_stat_t;

  typedef struct packed {
    logic       strap_s1;
    logic       strap_s2;
    logic       strap_done;
    logic       spi_mode;
    logic       en_s1;
    logic       en_s2;
    logic       en_prev;
    hppc_pwr_t  pwr;
    logic [19:0] por_cnt;
    logic [11:0] hold_cnt;
    logic       en_hold_err;
    logic       mod_allow;
    hppc_stat_t stat_s1;
    hppc_stat_t stat_s2;
    hppc_stat_t stat_prev;
    logic [11:0] pend;
    logic       int_oe;
    logic       int_o;
    logic [3:0] gpio_s1;
    logic [3:0] gpio_s2;
    logic [3:0] gpio_in;
    logic [3:0] gpio_oe;
    logic [3:0] gpio_o;
    logic       p1_s1;
    logic       p1_s2;
    logic       p2_s1;
    logic       p2_s2;
    logic       p3_s1;
    logic       p3_s2;
    logic       scl;
    logic       sda;
    logic       sda_o;
    logic       sda_oe;
    logic       set_addr_n;
    logic       led_in;
    logic       p4_o;
    logic       p4_oe;
    logic       tog_s1;
    logic       tog_s2;
    logic       tog_s3;
    logic [7:0] rx_byte;
    logic       rx_valid;
  } hppc_core_t;

  typedef struct packed {
    logic [7:0] sh;
    logic [7:0] rx;
    logic [7:0] tx;
    logic       tog;
    logic       miso;
  } hppc_link_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic       miso_oe;
  } hppc_frame_t;

endpackage : hppc_pkg

// ---- hppc_pin_ctrl.sv ----
`timescale 1ns/1ps
`include "hppc_params.svh"

module hppc_pin_ctrl #(
  parameter int unsigned POR_CYCLES = `HPPC_T_POR_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              host_protocol_strap,
  input  wire logic              host_pin_one,
  input  wire logic              host_pin_two_i,
  output logic                   host_pin_two_o,
  output logic                   host_pin_two_oe,
  input  wire logic              host_pin_three,
  output logic                   host_pin_four_o,
  output logic                   host_pin_four_oe,
  output logic                   host_pin_four_spi_o,
  output logic                   host_pin_four_spi_oe,
  input  wire logic              dev_enable,
  input  wire logic              supplies_stable,
  output logic                   host_int_o,
  output logic                   host_int_oe,
  input  wire hppc_pkg::hppc_stat_t port_stat,
  input  wire logic [11:0]       event_enable,
  input  wire logic [11:0]       event_clear,
  output logic [11:0]            event_pending,
  input  wire logic [3:0]        gpio_i,
  output logic [3:0]             gpio_o,
  output logic [3:0]             gpio_oe,
  input  wire logic [3:0]        gpio_dir_out,
  input  wire logic [3:0]        gpio_value,
  output logic [3:0]             gpio_level,
  input  wire logic              i2c_sda_pull,
  output logic                   i2c_scl,
  output logic                   i2c_sda,
  input  wire logic              addr_assigned,
  output logic                   addr_enable_n,
  output logic                   led_clk_in,
  input  wire logic              led_clk_local,
  input  wire logic              led_fwd_en,
  output logic [7:0]             spi_rx_byte,
  output logic                   spi_rx_valid,
  output logic                   spi_mode,
  output logic                   host_ready,
  output logic                   mod_xfer_allow,
  output logic                   en_hold_error
);

  localparam logic [19:0] POR_CNT  = 20'(POR_CYCLES);
  localparam logic [11:0] HOLD_CNT = 12'(`HPPC_EN_HOLD_CYC);

  hppc_pkg::hppc_core_t  c_r;
  hppc_pkg::hppc_core_t  c_nxt;
  hppc_pkg::hppc_link_t  l_r;
  hppc_pkg::hppc_link_t  l_nxt;
  hppc_pkg::hppc_frame_t f_r;
  hppc_pkg::hppc_frame_t f_nxt;

  logic       ready;
  logic       frame_idle;
  logic [11:0] stat_chg;

  assign ready      = (c_r.pwr == hppc_pkg::HPPC_READY);
  assign stat_chg   = c_r.stat_s2 ^ c_r.stat_prev;
  // the frame counter ends with the frame's own select, since the link clock stops between frames
  assign frame_idle = rst | host_pin_two_i | ~c_r.spi_mode;

  // ---------------- core domain ----------------
  always_comb begin
    c_nxt = c_r;

    // strap is caught once, after release, through two flops
    // waiting for the synced enable lets the strap chain drop its reset value first
    c_nxt.strap_s1 = host_protocol_strap;
    c_nxt.strap_s2 = c_r.strap_s1;
    if (!c_r.strap_done && c_r.pwr != hppc_pkg::HPPC_READY && c_r.en_s2) begin
      c_nxt.strap_done = 1'b1;
      c_nxt.spi_mode   = ~c_r.strap_s2;
    end

    // enable and power-on settling
    c_nxt.en_s1   = dev_enable;
    c_nxt.en_s2   = c_r.en_s1;
    c_nxt.en_prev = c_r.en_s2;
    case (c_r.pwr)
      hppc_pkg::HPPC_OFF: begin
        c_nxt.por_cnt = 20'h0_0000;
        if (c_r.en_s2 && supplies_stable && c_r.strap_done) begin
          c_nxt.pwr = hppc_pkg::HPPC_SETTLE;
        end
      end
      hppc_pkg::HPPC_SETTLE: begin
        if (!c_r.en_s2 || !supplies_stable) begin
          c_nxt.pwr = hppc_pkg::HPPC_OFF;
        end else if (c_r.por_cnt >= POR_CNT - 20'h0_0001) begin
          c_nxt.pwr     = hppc_pkg::HPPC_READY;
          c_nxt.por_cnt = POR_CNT;
        end else begin
          c_nxt.por_cnt = c_r.por_cnt + 20'h0_0001;
        end
      end
      hppc_pkg::HPPC_READY: begin
        if (!c_r.en_s2 || !supplies_stable) begin
          c_nxt.pwr = hppc_pkg::HPPC_OFF;
        end
      end
      default: c_nxt.pwr = hppc_pkg::HPPC_OFF;
    endcase
    c_nxt.mod_allow = c_r.en_s2 && (c_nxt.pwr == hppc_pkg::HPPC_READY);

    // flag an enable edge that comes before the hold time has run out
    if (c_r.en_s2 != c_r.en_prev) begin
      c_nxt.hold_cnt = 12'h000;
      if (c_r.hold_cnt < HOLD_CNT) begin
        c_nxt.en_hold_err = 1'b1;
      end
    end else if (c_r.hold_cnt < HOLD_CNT) begin
      c_nxt.hold_cnt = c_r.hold_cnt + 12'h001;
    end

    // status inputs; reset value high matches the weak pull-ups
    c_nxt.stat_s1   = port_stat;
    c_nxt.stat_s2   = c_r.stat_s1;
    c_nxt.stat_prev = c_r.stat_s2;
    // a change in the same cycle as a clear stays pending
    c_nxt.pend   = (c_r.pend & ~event_clear) | stat_chg;
    c_nxt.int_oe = |(c_nxt.pend & event_enable);
    c_nxt.int_o  = 1'b0;

    // gpio
    c_nxt.gpio_s1 = gpio_i;
    c_nxt.gpio_s2 = c_r.gpio_s1;
    c_nxt.gpio_in = c_r.gpio_s2;
    c_nxt.gpio_oe = gpio_dir_out;
    c_nxt.gpio_o  = gpio_value;

    // host pins; engines see an idle bus while not ready
    c_nxt.p1_s1 = host_pin_one;
    c_nxt.p1_s2 = c_r.p1_s1;
    c_nxt.p2_s1 = host_pin_two_i;
    c_nxt.p2_s2 = c_r.p2_s1;
    c_nxt.p3_s1 = host_pin_three;
    c_nxt.p3_s2 = c_r.p3_s1;
    c_nxt.scl        = (ready && !c_r.spi_mode) ? c_r.p1_s2 : 1'b1;
    c_nxt.sda        = (ready && !c_r.spi_mode) ? c_r.p2_s2 : 1'b1;
    c_nxt.sda_o      = 1'b0;
    c_nxt.sda_oe     = (c_nxt.pwr == hppc_pkg::HPPC_READY) && !c_r.spi_mode && i2c_sda_pull;
    c_nxt.set_addr_n = c_r.spi_mode ? 1'b1 : c_r.p3_s2;
    c_nxt.led_in     = c_r.spi_mode ? 1'b0 : c_r.p3_s2;
    // pin four carries either the done flag or the forwarded led clock
    c_nxt.p4_o  = led_fwd_en ? led_clk_local : ~addr_assigned;
    c_nxt.p4_oe = c_r.strap_done && !c_r.spi_mode;

    // received spi byte, announced by a toggle from the link side
    c_nxt.tog_s1   = l_r.tog;
    c_nxt.tog_s2   = c_r.tog_s1;
    c_nxt.tog_s3   = c_r.tog_s2;
    c_nxt.rx_valid = 1'b0;
    if (c_r.tog_s2 != c_r.tog_s3 && c_nxt.pwr == hppc_pkg::HPPC_READY && c_r.spi_mode) begin
      c_nxt.rx_byte  = l_r.rx;
      c_nxt.rx_valid = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_r           <= '0;
      c_r.strap_s1  <= 1'b1;
      c_r.strap_s2  <= 1'b1;
      c_r.pwr       <= hppc_pkg::HPPC_OFF;
      c_r.hold_cnt  <= HOLD_CNT;
      c_r.stat_s1   <= `HPPC_RST_STAT;
      c_r.stat_s2   <= `HPPC_RST_STAT;
      c_r.stat_prev <= `HPPC_RST_STAT;
      c_r.gpio_oe   <= `HPPC_RST_GPIO;
      c_r.p1_s1     <= 1'b1;
      c_r.p1_s2     <= 1'b1;
      c_r.p2_s1     <= 1'b1;
      c_r.p2_s2     <= 1'b1;
      c_r.p3_s1     <= 1'b1;
      c_r.p3_s2     <= 1'b1;
      c_r.scl       <= 1'b1;
      c_r.sda       <= 1'b1;
      c_r.set_addr_n <= 1'b1;
      c_r.p4_o      <= 1'b1;
      c_r.rx_byte   <= `HPPC_RST_BYTE;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ---------------- link domain (spi clock on pin one) ----------------
  // limitation: miso changes on the rising edge, so the host must sample it one edge late
  always_comb begin
    l_nxt      = l_r;
    l_nxt.sh   = {l_r.sh[6:0], host_pin_three};
    l_nxt.tx   = {l_r.tx[6:0], 1'b0};
    if (f_r.cnt == 3'd7) begin
      l_nxt.rx  = {l_r.sh[6:0], host_pin_three};
      l_nxt.tog = ~l_r.tog;
      l_nxt.tx  = {l_r.sh[6:0], host_pin_three};
    end
    l_nxt.miso = l_nxt.tx[7];
    f_nxt.cnt     = f_r.cnt + 3'd1;
    f_nxt.miso_oe = 1'b1;
  end

  // runs only while selected; echoes the previous byte back on miso
  always_ff @(posedge host_pin_one or posedge rst) begin
    if (rst) begin
      l_r <= '0;
    end else if (!host_pin_two_i && c_r.spi_mode) begin
      l_r <= l_nxt;
    end
  end

  always_ff @(posedge host_pin_one or posedge frame_idle) begin
    if (frame_idle) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  // ---------------- outputs ----------------
  assign host_pin_two_o       = c_r.sda_o;
  assign host_pin_two_oe      = c_r.sda_oe;
  assign host_pin_four_o      = c_r.p4_o;
  assign host_pin_four_oe     = c_r.p4_oe;
  assign host_pin_four_spi_o  = l_r.miso;
  assign host_pin_four_spi_oe = f_r.miso_oe;
  assign host_int_o           = c_r.int_o;
  assign host_int_oe          = c_r.int_oe;
  assign event_pending        = c_r.pend;
  assign gpio_o               = c_r.gpio_o;
  assign gpio_oe              = c_r.gpio_oe;
  assign gpio_level           = c_r.gpio_in;
  assign i2c_scl              = c_r.scl;
  assign i2c_sda              = c_r.sda;
  assign addr_enable_n        = c_r.set_addr_n;
  assign led_clk_in           = c_r.led_in;
  assign spi_rx_byte          = c_r.rx_byte;
  assign spi_rx_valid         = c_r.rx_valid;
  assign spi_mode             = c_r.spi_mode;
  assign host_ready           = c_r.pwr[1];
  assign mod_xfer_allow       = c_r.mod_allow;
  assign en_hold_error        = c_r.en_hold_err;

  // ---------------- assertions ----------------
  a_int_low_only: assert property (@(posedge clk) disable iff (rst)
    host_int_o == 1'b0 && $stable(host_int_o))
    else $error("interrupt pin driven high");

  a_int_assert: assert property (@(posedge clk) disable iff (rst)
    ($changed(c_r.stat_s2) && (stat_chg & event_enable) != 12'h000 && $stable(event_enable))
      |=> host_int_oe)
    else $error("enabled event did not pull interrupt low");

  a_int_release: assert property (@(posedge clk) disable iff (rst)
    ((event_pending & event_enable) != 12'h000 ##1
     (((event_pending & ~event_clear) | stat_chg) & event_enable) == 12'h000)
      |=> !host_int_oe)
    else $error("interrupt not released after clear");

  a_off_quiet: assert property (@(posedge clk) disable iff (rst)
    !c_r.en_s2 |=> !mod_xfer_allow && !spi_rx_valid && !host_pin_two_oe)
    else $error("activity while disabled");

  a_por_wait: assert property (@(posedge clk) disable iff (rst)
    $rose(host_ready) |-> $past(c_r.pwr) == hppc_pkg::HPPC_SETTLE && c_r.por_cnt == POR_CNT)
    else $error("ready before settling time");

  a_gpio_input: assert property (@(posedge clk) disable iff (rst)
    gpio_dir_out == 4'h0 |=> gpio_oe == 4'h0)
    else $error("gpio driven without configuration");

  a_addr_done: assert property (@(posedge clk) disable iff (rst)
    (!spi_mode && c_r.strap_done && !led_fwd_en && addr_assigned)
      |=> host_pin_four_oe && !host_pin_four_o)
    else $error("address done not shown on pin four");

  a_sda_open: assert property (@(posedge clk) disable iff (rst)
    host_pin_two_oe |-> !host_pin_two_o && !spi_mode && $past(i2c_sda_pull))
    else $error("data pin driven high or in spi mode");

  a_addr_in: assert property (@(posedge clk) disable iff (rst)
    (!spi_mode && !c_r.p3_s2) |=> !addr_enable_n && led_clk_in == 1'b0)
    else $error("address enable not followed");

  a_strap_held: assert property (@(posedge clk) disable iff (rst)
    c_r.strap_done |=> $stable(spi_mode))
    else $error("host mode changed after strap capture");

  a_spi_pins_idle: assert property (@(posedge clk) disable iff (rst)
    spi_mode |=> i2c_scl && i2c_sda && addr_enable_n && !led_clk_in && !host_pin_four_oe)
    else $error("i2c side active in spi mode");

  a_rx_one_cycle: assert property (@(posedge clk) disable iff (rst)
    spi_rx_valid |=> !spi_rx_valid)
    else $error("received byte strobe longer than one cycle");

  a_led_in: assert property (@(posedge clk) disable iff (rst)
    (!spi_mode && c_r.p3_s2) |=> led_clk_in && addr_enable_n)
    else $error("led clock input not followed");

  a_led_fwd: assert property (@(posedge clk) disable iff (rst)
    (!spi_mode && c_r.strap_done && led_fwd_en)
      |=> host_pin_four_oe && host_pin_four_o == $past(led_clk_local))
    else $error("led clock not forwarded on pin four");

  a_ready_enabled: assert property (@(posedge clk) disable iff (rst)
    host_ready |-> $past(c_r.en_s2) && $past(supplies_stable))
    else $error("ready while disabled or unpowered");

  a_hold_sticky: assert property (@(posedge clk) disable iff (rst)
    en_hold_error |=> en_hold_error)
    else $error("enable hold error lost");

  a_gpio_follow: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> gpio_oe == $past(gpio_dir_out) && gpio_o == $past(gpio_value))
    else $error("gpio direction or value not taken");

  a_event_latch: assert property (@(posedge clk) disable iff (rst)
    $changed(c_r.stat_s2) |=> (event_pending & $past(stat_chg)) == $past(stat_chg))
    else $error("status change not latched as pending");

  a_int_idle: assert property (@(posedge clk) disable iff (rst)
    ((event_pending & event_enable) == 12'h000 && $stable(event_enable)) |-> !host_int_oe)
    else $error("interrupt held with nothing pending");

endmodule : hppc_pin_ctrl

// ---- hppc_host.sv ----
`timescale 1ns/1ps
module hppc_host (
  output logic        sck,
  output logic        ss_n,
  output logic        mosi,
  input  wire logic   miso,
  output logic [15:0] cap
);
  // sck stands still outside frames; mosi is not left showing its last bit
  initial begin
    sck  = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
    cap  = 16'h0000;
  end

  // miso moves on the rising sck, so the far side takes it on the falling one
  always @(negedge sck) cap <= {cap[14:0], miso};

  // one frame, msb first, 32 ns sck
  task automatic frame(input logic [15:0] d);
    ss_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = d[i];
      #16 sck = 1'b1;
      #16 sck = 1'b0;
    end
    #16 ss_n = 1'b1;
    mosi = ~mosi;
  endtask : frame
endmodule : hppc_host

// ---- hppc_pin_ctrl_tb.sv ----
`timescale 1ns/1ps
module hppc_pin_ctrl_tb;
  localparam int POR = 20;
  logic                 clk, rst, host_protocol_strap, dev_enable, supplies_stable, i2c_sda_pull;
  logic                 addr_assigned, led_clk_local, led_fwd_en, p3;
  hppc_pkg::hppc_stat_t port_stat;
  logic [11:0]          event_enable, event_clear, event_pending;
  logic [3:0]           gpio_i, gpio_dir_out, gpio_value, gpio_o, gpio_oe, gpio_level;
  logic                 host_pin_two_o, host_pin_two_oe, host_pin_four_o, host_pin_four_oe;
  logic                 host_pin_four_spi_o, host_pin_four_spi_oe, host_int_o, host_int_oe;
  logic                 i2c_scl, i2c_sda, addr_enable_n, led_clk_in, spi_rx_valid, spi_mode;
  logic                 host_ready, mod_xfer_allow, en_hold_error, sck, ss_n, mosi;
  logic [7:0]           spi_rx_byte;
  logic [15:0]          cap;
  int                   failures, cmp_count, cyc, nv;
  // open-drain data: host and device each can only pull low
  wire host_pin_one   = sck;
  wire host_pin_two_i = ss_n & ~host_pin_two_oe;
  wire host_pin_three = host_protocol_strap ? p3 : mosi;
  wire pin_four       = host_pin_four_spi_oe ? host_pin_four_spi_o : (host_pin_four_oe ? host_pin_four_o : 1'bz);

  hppc_pin_ctrl #(.POR_CYCLES(POR)) u_dut (
    .clk, .rst, .host_protocol_strap, .host_pin_one, .host_pin_two_i, .host_pin_two_o,
    .host_pin_two_oe, .host_pin_three, .host_pin_four_o, .host_pin_four_oe, .host_pin_four_spi_o,
    .host_pin_four_spi_oe, .dev_enable, .supplies_stable, .host_int_o, .host_int_oe, .port_stat,
    .event_enable, .event_clear, .event_pending, .gpio_i, .gpio_o, .gpio_oe, .gpio_dir_out,
    .gpio_value, .gpio_level, .i2c_sda_pull, .i2c_scl, .i2c_sda, .addr_assigned, .addr_enable_n,
    .led_clk_in, .led_clk_local, .led_fwd_en, .spi_rx_byte, .spi_rx_valid, .spi_mode,
    .host_ready, .mod_xfer_allow, .en_hold_error
  );

  hppc_host u_host (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(pin_four), .cap(cap));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic do_reset(input logic s);
    int k;
    @(negedge clk);
    rst = 1'b1;
    host_protocol_strap = s;
    supplies_stable = 1'b0;
    repeat (16) @(negedge clk);
    check({gpio_oe, host_int_oe, host_pin_two_oe, host_ready}, 7'h00);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    supplies_stable = 1'b1;
    for (k = 0; k < 60 && host_ready !== 1'b1; k++) @(negedge clk);
    check(k >= POR && k <= POR + 4, 1);
    check(mod_xfer_allow, 1);
  endtask : do_reset

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // long counts would stall the run; the ceiling turns a hang into a fail
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (spi_rx_valid === 1'b1) nv <= nv + 1;
    if (cyc == 12000) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    int k;
    rst = 1'b1;
    host_protocol_strap = 1'b1;
    dev_enable = 1'b1;
    supplies_stable = 1'b0;
    {i2c_sda_pull, addr_assigned, led_clk_local, led_fwd_en} = 4'h0;
    p3 = 1'b1;
    port_stat = 12'hfff;
    event_enable = 12'h000;
    event_clear = 12'h000;
    {gpio_i, gpio_dir_out, gpio_value} = 12'h000;
    do_reset(1'b1);
    check({spi_mode, host_pin_four_oe}, 2'b01);
    $display("test reset done");
    u_host.ss_n = 1'b0;
    repeat (5) @(negedge clk);
    check({i2c_scl, i2c_sda}, 2'b00);
    u_host.ss_n = 1'b1;
    i2c_sda_pull = 1'b1;
    repeat (6) @(negedge clk);
    check({host_pin_two_oe, host_pin_two_o, i2c_sda}, 3'b100);
    i2c_sda_pull = 1'b0;
    p3 = 1'b0;
    addr_assigned = 1'b1;
    repeat (5) @(negedge clk);
    check({addr_enable_n, led_clk_in, pin_four}, 3'b000);
    led_fwd_en = 1'b1;
    led_clk_local = 1'b1;
    repeat (2) @(negedge clk);
    check(pin_four, 1);
    p3 = 1'b1;
    repeat (5) @(negedge clk);
    check({addr_enable_n, led_clk_in}, 2'b11);
    $display("test i2c pins done");
    event_enable = 12'h020;
    port_stat = 12'hfde;
    repeat (7) @(negedge clk);
    check({event_pending, host_int_oe, host_int_o}, {12'h021, 2'b10});
    event_clear = 12'h020;
    @(negedge clk);
    event_clear = 12'h000;
    repeat (2) @(negedge clk);
    check({event_pending, host_int_oe}, {12'h001, 1'b0});
    $display("test events done");
    gpio_dir_out = 4'ha;
    gpio_value = 4'hc;
    gpio_i = 4'h5;
    repeat (5) @(negedge clk);
    check({gpio_oe, gpio_o, gpio_level}, 12'hac5);
    $display("test gpio done");
    repeat (2600) @(negedge clk);
    dev_enable = 1'b0;
    repeat (5) @(negedge clk);
    check({host_ready, mod_xfer_allow, en_hold_error}, 3'b000);
    dev_enable = 1'b1;
    repeat (5) @(negedge clk);
    check(en_hold_error, 1);
    $display("test enable done");
    do_reset(1'b0);
    check({spi_mode, host_pin_four_oe, i2c_scl, i2c_sda, addr_enable_n}, 5'b10111);
    k = nv;
    u_host.frame(16'ha53c);
    repeat (8) @(negedge clk);
    check({spi_rx_byte, cap[8:1], host_pin_four_spi_oe}, {8'h3c, 8'ha5, 1'b0});
    check(nv - k, 2);
    $display("test spi done");
    complete_run();
  end
endmodule : hppc_pin_ctrl_tb
